// ==== core/hssc_core.sv ====
// hssc_core: control, protection and fault reporting for two high-side switches
// assumes analog sense and supply/temperature comparators arrive asynchronously
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - each switch turns on from its own enable bit in switch control.
// - enable plus pwm gate makes the switch follow the pwm input pin.
// - open-load flags per switch at status bits 1 and 3.
// - current-limit flags per switch at status bits 0 and 2.
// - overtemperature turns both off, latches event, source code 0010.
// - thermal shutdown sets all four status flags together.
// - interrupt output drives low for overtemperature only when mask bit set.
// - masked source keeps interrupt high and does not set source flags.
// - after overtemperature, off until condition gone then control written.
// - with overvoltage shutdown enabled, overvoltage turns both switches off.
// - re-enable after overvoltage only by control write once condition gone.
// - interrupts only in normal, normal request or stop mode.
// - switches may stay enabled during sleep and stop modes.
// - switch control at address 6: pwm gates bits 3,2, enables bits 1,0.
// - mode control at address 0 holds overvoltage shutdown enable in bit 3.
module hssc_core
    import hssc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // pins and comparators
    input wire logic pwmInputPin,
    input wire logic overTemp,
    input wire logic overVoltage,
    input wire hssc_sense_s sense1,
    input wire hssc_sense_s sense2,
    input wire hssc_mode_e opMode,
    // outputs
    output logic switchOneOn,
    output logic switchTwoOn,
    output logic irqN
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed
    {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [3:0] swCtrl;
        logic [3:0] modeCtrl;
        logic [1:0] irqMask;
        logic [1:0] irqStat;
        logic [3:0] swStatus;
        hssc_prot_e prot;
        logic [7:0] rdData;
        logic sw1On;
        logic sw2On;
        logic irqN;
    } hssc_state_s;

    hssc_state_s state_q;
    hssc_state_s state_d;

    // synchronised view: {pwm, ot, ov, ol1, cl1, ol2, cl2, spare}
    logic pwmS;
    logic otS;
    logic ovS;
    logic ol1S;
    logic cl1S;
    logic ol2S;
    logic cl2S;
    assign pwmS = state_q.sync2[7];
    assign otS = state_q.sync2[6];
    assign ovS = state_q.sync2[5];
    assign ol1S = state_q.sync2[4];
    assign cl1S = state_q.sync2[3];
    assign ol2S = state_q.sync2[2];
    assign cl2S = state_q.sync2[1];

    // switch drive from enable and pwm gate
    function automatic logic switchDrive(input logic en, input logic gate, input logic pwm);
        switchDrive = en & (~gate | pwm);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        logic ctrlWr;
        logic shutdownNow;
        logic irqAllowed;
        logic [1:0] events;
        logic [3:0] src;
        ctrlWr = 1'b0;
        shutdownNow = 1'b0;
        irqAllowed = 1'b0;
        events = 2'h0;
        src = SRC_NONE;
        state_d = state_q;

        // two-stage synchroniser for the pwm pin, comparator and sense levels; opMode is used directly
        state_d.sync1 = {pwmInputPin, overTemp, overVoltage, sense1.openLoad,
                         sense1.currentLimit, sense2.openLoad, sense2.currentLimit, 1'b0};
        state_d.sync2 = state_q.sync1;

        // register writes
        ctrlWr = regWrite && (regAddr == ADDR_SW_CTRL);
        if (ctrlWr)
        begin
            state_d.swCtrl = regWrData[3:0];
        end
        if (regWrite && (regAddr == ADDR_MODE_CTRL))
        begin
            state_d.modeCtrl = {regWrData[OV_SHDN_EN_BIT], 3'h0};
        end
        if (regWrite && (regAddr == ADDR_IRQ_MASK))
        begin
            state_d.irqMask = regWrData[1:0];
        end

        // protection: off on fault, armed once faults gone, run on control write
        shutdownNow = otS | (ovS & state_q.modeCtrl[OV_SHDN_EN_BIT]);
        case (state_q.prot)
            HSSC_PROT_RUN:
            begin
                if (shutdownNow)
                begin
                    state_d.prot = HSSC_PROT_OFF;
                end
            end
            HSSC_PROT_OFF:
            begin
                if (!otS && !ovS)
                begin
                    state_d.prot = HSSC_PROT_ARMED;
                end
            end
            HSSC_PROT_ARMED:
            begin
                if (shutdownNow)
                begin
                    state_d.prot = HSSC_PROT_OFF;
                end
                else if (ctrlWr)
                begin
                    state_d.prot = HSSC_PROT_RUN;
                end
            end
            default:
            begin
                state_d.prot = HSSC_PROT_OFF;
            end
        endcase

        // switch outputs; no mode gating so sleep/stop keep them on
        if (state_q.prot == HSSC_PROT_RUN && !shutdownNow)
        begin
            state_d.sw1On = switchDrive(state_q.swCtrl[SW1_EN_BIT],
                                        state_q.swCtrl[SW1_PWM_BIT], pwmS);
            state_d.sw2On = switchDrive(state_q.swCtrl[SW2_EN_BIT],
                                        state_q.swCtrl[SW2_PWM_BIT], pwmS);
        end
        else
        begin
            state_d.sw1On = 1'b0;
            state_d.sw2On = 1'b0;
        end

        // status flags follow sense, all set while thermally shut down
        if (otS || (state_q.prot != HSSC_PROT_RUN && state_q.irqStat[IRQ_OT_BIT]))
        begin
            state_d.swStatus = 4'hf;
        end
        else
        begin
            state_d.swStatus[SW1_OL_BIT] = ol1S;
            state_d.swStatus[SW2_OL_BIT] = ol2S;
            state_d.swStatus[SW1_CL_BIT] = cl1S;
            state_d.swStatus[SW2_CL_BIT] = cl2S;
        end

        // sticky events, masked ones never set; set wins over clear
        irqAllowed = (opMode == HSSC_MODE_NORMAL) || (opMode == HSSC_MODE_NORMAL_REQ)
                     || (opMode == HSSC_MODE_STOP);
        events[IRQ_OT_BIT] = otS && (state_q.prot == HSSC_PROT_RUN);
        events[IRQ_OV_BIT] = ovS && state_q.modeCtrl[OV_SHDN_EN_BIT]
                             && (state_q.prot == HSSC_PROT_RUN);
        events = events & state_q.irqMask & {2{irqAllowed}};
        if (regWrite && (regAddr == ADDR_IRQ_STATUS))
        begin
            state_d.irqStat = state_q.irqStat & ~regWrData[1:0];
        end
        state_d.irqStat = state_d.irqStat | events;

        // interrupt output low while an unmasked event is pending
        state_d.irqN = ~(|(state_d.irqStat & state_d.irqMask));

        // source code, switch event has priority
        if (state_q.irqStat[IRQ_OT_BIT])
        begin
            src = SRC_SWITCH;
        end
        else if (state_q.irqStat[IRQ_OV_BIT])
        begin
            src = SRC_SUPPLY;
        end

        // read data, one cycle after the strobe, zero otherwise
        state_d.rdData = 8'h00;
        if (regRead)
        begin
            case (regAddr)
                ADDR_MODE_CTRL: state_d.rdData = {4'h0, state_q.modeCtrl};
                ADDR_SW_CTRL: state_d.rdData = {4'h0, state_q.swCtrl};
                ADDR_SW_STATUS: state_d.rdData = {4'h0, state_q.swStatus};
                ADDR_IRQ_MASK: state_d.rdData = {6'h00, state_q.irqMask};
                ADDR_IRQ_STATUS: state_d.rdData = {6'h00, state_q.irqStat};
                ADDR_IRQ_SOURCE: state_d.rdData = {4'h0, src};
                default: state_d.rdData = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= '{sync1: 8'h00, sync2: 8'h00, swCtrl: SW_CTRL_RST,
                         modeCtrl: MODE_CTRL_RST, irqMask: IRQ_MASK_RST, irqStat: 2'h0,
                         swStatus: 4'h0, prot: HSSC_PROT_RUN, rdData: 8'h00,
                         sw1On: 1'b0, sw2On: 1'b0, irqN: 1'b1};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // outputs straight from flip-flops
    assign regRdData = state_q.rdData;
    assign switchOneOn = state_q.sw1On;
    assign switchTwoOn = state_q.sw2On;
    assign irqN = state_q.irqN;

endmodule // hssc_core

// ==== include/hssc_pkg.sv ====
// hssc_pkg: constants and types for the high-side switch control block
// assumes one 20 MHz clock and a plain register port with 4-bit addresses
package hssc_pkg;
    // register addresses
    localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SW_CTRL = 4'h6;
    localparam logic [3:0] ADDR_SW_STATUS = 4'h7;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h9;
    localparam logic [3:0] ADDR_IRQ_SOURCE = 4'ha;
    // switch control field positions
    localparam int SW1_EN_BIT = 0;
    localparam int SW2_EN_BIT = 1;
    localparam int SW1_PWM_BIT = 2;
    localparam int SW2_PWM_BIT = 3;
    // mode control field position
    localparam int OV_SHDN_EN_BIT = 3;
    // switch status field positions
    localparam int SW1_CL_BIT = 0;
    localparam int SW1_OL_BIT = 1;
    localparam int SW2_CL_BIT = 2;
    localparam int SW2_OL_BIT = 3;
    // interrupt status / mask bits
    localparam int IRQ_OT_BIT = 0;
    localparam int IRQ_OV_BIT = 1;
    // interrupt source codes
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_SWITCH = 4'h2;
    localparam logic [3:0] SRC_SUPPLY = 4'h5;
    // reset values
    localparam logic [3:0] SW_CTRL_RST = 4'h0;
    localparam logic [3:0] MODE_CTRL_RST = 4'h0;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    // operating modes of the surrounding device
    typedef enum logic [3:0]
    {
        HSSC_MODE_NORMAL = 4'b0001,
        HSSC_MODE_NORMAL_REQ = 4'b0010,
        HSSC_MODE_STOP = 4'b0100,
        HSSC_MODE_SLEEP = 4'b1000
    } hssc_mode_e;
    // analog sense inputs per switch
    typedef struct packed
    {
        logic openLoad;
        logic currentLimit;
    } hssc_sense_s;
    // protection state
    typedef enum logic [2:0]
    {
        HSSC_PROT_RUN = 3'b001,
        HSSC_PROT_OFF = 3'b010,
        HSSC_PROT_ARMED = 3'b100
    } hssc_prot_e;
endpackage

// ==== verif/hssc_core_asserts.sv ====
// hssc_core_asserts: port-level checks for hssc_core
// assumes one clock domain and a bench that strobes one access at a time
`timescale 1ns/1ps
module hssc_core_asserts
    import hssc_pkg::*;
(
    // clock, reset and register port
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    // pins and comparators
    input wire logic pwmInputPin,
    input wire logic overTemp,
    input wire logic overVoltage,
    input wire hssc_sense_s sense1,
    input wire hssc_sense_s sense2,
    input wire hssc_mode_e opMode,
    // switch and interrupt outputs
    input wire logic switchOneOn,
    input wire logic switchTwoOn,
    input wire logic irqN
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [1:0] mask_q;
    logic ovEn_q;
    ////////////////////////
    // shadow of the mask and the overvoltage shutdown enable
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) {mask_q, ovEn_q} <= 3'h0;
        else if (regWrite && regAddr == ADDR_IRQ_MASK) mask_q <= regWrData[1:0];
        else if (regWrite && regAddr == ADDR_MODE_CTRL) ovEn_q <= regWrData[3];
    ////////////////////////
    // fault and access sequences
    sequence otHeld; overTemp[*4]; endsequence
    sequence otEvent; $rose(overTemp) && switchOneOn && mask_q[IRQ_OT_BIT]
        && opMode == HSSC_MODE_NORMAL ##1 overTemp[*4]; endsequence
    sequence calm; $stable(sense1) && $stable(sense2) && !overTemp; endsequence
    sequence stRead; regRead && regAddr == ADDR_SW_STATUS; endsequence
    // checks
    a_ot_off: assert property (otHeld |=> !switchOneOn && !switchTwoOn)
        else $error("switch on during overtemperature");
    a_ot_flags: assert property (otHeld ##0 stRead |=> regRdData == 8'h0f)
        else $error("status not all set");
    a_ot_irq: assert property (otEvent |-> ##[0:3] !irqN)
        else $error("no interrupt for overtemperature");
    a_mask_quiet: assert property ($fell(irqN) |-> mask_q != 2'h0)
        else $error("interrupt while masked");
    a_mode_quiet: assert property ($fell(irqN) |-> $past(opMode) != HSSC_MODE_SLEEP)
        else $error("interrupt in sleep");
    a_ov_off: assert property ((ovEn_q && overVoltage)[*4] |=> !switchOneOn && !switchTwoOn)
        else $error("switch on during overvoltage");
    a_status_live: assert property (calm[*4] ##0 stRead ##0 switchOneOn
        |=> regRdData == {4'h0, $past({sense2, sense1})}) else $error("status mismatch");
    a_rd_idle: assert property (!regRead |=> regRdData == 8'h00)
        else $error("read data outside read slot");
endmodule // hssc_core_asserts
bind hssc_core hssc_core_asserts i_hssc_core_asserts (.*);

// ==== verif/hssc_pwm_src.sv ====
// hssc_pwm_src: controller side driving the pwm input pin
// assumes the block clock; the pin rests low while run is low
`timescale 1ns/1ps
module hssc_pwm_src #(parameter int HALF = 5)
(
    // clock and enable
    input wire logic clk,
    input wire logic run,
    // pwm pin
    output logic pwmPin = 1'h0
);
    logic [7:0] cnt_q = 8'h00;
    // square wave of 2*HALF cycles
    always @(posedge clk)
        if (!run) {cnt_q, pwmPin} <= 9'h000;
        else if (cnt_q == 8'(HALF - 1)) {cnt_q, pwmPin} <= {8'h00, !pwmPin};
        else cnt_q <= cnt_q + 8'h01;
endmodule // hssc_pwm_src

// ==== verif/tb_high_side_switch_control.sv ====
// tb_high_side_switch_control: scenario bench for hssc_core
// assumes the checker binds itself and hssc_pwm_src drives the pin
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_high_side_switch_control
    import hssc_pkg::*;
;
    logic clk = 1'h0, rstn = 1'h0, regWrite = 1'h0, regRead = 1'h0, pwmRun = 1'h0;
    logic overTemp = 1'h0, overVoltage = 1'h0, pwmInputPin, switchOneOn, switchTwoOn, irqN;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00, regRdData;
    logic [2:0] pinHist = 3'h0;
    hssc_sense_s sense1 = 2'h0, sense2 = 2'h0;
    hssc_mode_e opMode = HSSC_MODE_NORMAL;
    int failures = 0, num_checks = 0, cycles = 0;
    ////////////////////////
    // design, pin source, clock, pin history
    hssc_core i_hssc_core (.*);
    hssc_pwm_src i_hssc_pwm_src (.clk(clk), .run(pwmRun), .pwmPin(pwmInputPin));
    initial forever #25 clk = !clk;
    always @(posedge clk) pinHist <= {pinHist[1:0], pwmInputPin};
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            failures++;
            conclude();
        end
    end
    ////////////////////////
    // bus cycles and output sampling
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        {regAddr, regWrData, regWrite} <= {a, d, 1'h1};
        @(posedge clk) regWrite <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        {regAddr, regRead} <= {a, 1'h1};
        @(posedge clk) regRead <= 1'h0;
        @(negedge clk) `CHK(regRdData, e)
        @(posedge clk);
    endtask
    task automatic sw(input int n, input logic [2:0] e);
        repeat (n) @(posedge clk);
        @(negedge clk) `CHK({irqN, switchTwoOn, switchOneOn}, e)
        @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////
    // scenarios
    task automatic t_regs();
        wr(4'h3, 8'hff);
        rd(4'h3, 8'h00);
        wr(ADDR_MODE_CTRL, 8'h07);
        rd(ADDR_MODE_CTRL, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_SW_CTRL, 8'(i));
            sw(2, {1'h1, i[1:0]});
        end
    endtask
    task automatic t_pwm();
        logic [3:0] cfg [3] = '{4'hf, 4'hd, 4'h6};
        pwmRun <= 1'h1;
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_SW_CTRL, {4'h0, cfg[k]});
            repeat (20)
            begin
                @(negedge clk);
                `CHK(switchOneOn, cfg[k][0] & (!cfg[k][2] | pinHist[2]))
                `CHK(switchTwoOn, cfg[k][1] & (!cfg[k][3] | pinHist[2]))
            end
            @(posedge clk);
        end
        pwmRun <= 1'h0;
    endtask
    task automatic t_status();
        wr(ADDR_SW_CTRL, 8'h03);
        for (int i = 0; i < 16; i++)
        begin
            {sense2, sense1} <= 4'(i);
            repeat (4) @(posedge clk);
            rd(ADDR_SW_STATUS, 8'(i));
        end
        {sense2, sense1} <= 4'h0;
    endtask
    task automatic t_ot();
        logic m;
        for (int k = 1; k >= 0; k--)
        begin
            m = k[0];
            wr(ADDR_IRQ_MASK, {7'h00, m});
            overTemp <= 1'h1;
            sw(5, {!m, 2'h0});
            rd(ADDR_SW_STATUS, 8'h0f);
            rd(ADDR_IRQ_SOURCE, {4'h0, m ? SRC_SWITCH : SRC_NONE});
            wr(ADDR_SW_CTRL, 8'h03);
            overTemp <= 1'h0;
            sw(4, {!m, 2'h0});
            wr(ADDR_IRQ_MASK, 8'h01);
            sw(2, {!m, 2'h0});
            wr(ADDR_IRQ_STATUS, 8'h01);
            wr(ADDR_SW_CTRL, 8'h03);
            sw(2, 3'h7);
        end
    endtask
    task automatic t_ov();
        overVoltage <= 1'h1;
        sw(5, 3'h7);
        overVoltage <= 1'h0;
        sw(3, 3'h7);
        wr(ADDR_MODE_CTRL, 8'h08);
        rd(ADDR_MODE_CTRL, 8'h08);
        wr(ADDR_IRQ_MASK, 8'h02);
        overVoltage <= 1'h1;
        sw(5, 3'h0);
        rd(ADDR_IRQ_SOURCE, {4'h0, SRC_SUPPLY});
        wr(ADDR_SW_CTRL, 8'h03);
        overVoltage <= 1'h0;
        sw(4, 3'h0);
        wr(ADDR_IRQ_STATUS, 8'h02);
        wr(ADDR_SW_CTRL, 8'h03);
        sw(2, 3'h7);
    endtask
    task automatic t_mode();
        opMode <= HSSC_MODE_SLEEP;
        wr(ADDR_IRQ_MASK, 8'h01);
        sw(2, 3'h7);
        overTemp <= 1'h1;
        sw(5, 3'h4);
        for (int k = 0; k < 2; k++)
        begin
            overTemp <= 1'h0;
            repeat (4) @(posedge clk);
            opMode <= k ? HSSC_MODE_STOP : HSSC_MODE_NORMAL_REQ;
            wr(ADDR_IRQ_STATUS, 8'h03);
            wr(ADDR_SW_CTRL, 8'h03);
            sw(2, 3'h7);
            overTemp <= 1'h1;
            sw(5, 3'h0);
        end
        overTemp <= 1'h0;
    endtask
    // reset, then the scenarios in turn
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        t_regs();
        t_pwm();
        t_status();
        t_ot();
        t_ov();
        t_mode();
        conclude();
    end
endmodule // tb_high_side_switch_control
